//--- include/csm_pkg.sv
package csm_pkg;

    localparam int unsigned CSM_ADDR_W = 17;
    localparam int unsigned CSM_DATA_W = 8;

    // Register addresses
    localparam logic [16:0] CSM_KEY_AGREEMENT_MODE_ADDR = 17'h1060A;
    localparam logic [16:0] CSM_ID_COUNTER_BACKUP_CTRL_ADDR = 17'h1060B;
    localparam logic [16:0] CSM_MEMORY_OVERWRITE_MODE_ADDR = 17'h1060F;
    localparam logic [16:0] CSM_SYM_CIPHER_LEVEL2_MODE_ADDR = 17'h10619;

    // Field widths and backup bit position
    localparam int unsigned CSM_KA_W = 3;
    localparam int unsigned CSM_OW_W = 3;
    localparam int unsigned CSM_L2_W = 4;
    localparam int unsigned CSM_BACKUP_BIT = 0;

    // Reset values
    localparam logic [2:0] CSM_KA_RST = 3'h0;
    localparam logic [2:0] CSM_OW_RST = 3'h0;
    localparam logic [3:0] CSM_L2_RST = 4'h0;
    localparam logic CSM_BACKUP_RST = 1'b0;

    // Key-agreement codes
    localparam logic [2:0] CSM_KEY_AGREEMENT_IDLE = 3'h1;
    localparam logic [2:0] CSM_KEY_AGREEMENT_KEYGEN = 3'h2;
    localparam logic [2:0] CSM_KEY_AGREEMENT_ENCDEC = 3'h3;

    // Overwrite controller codes
    localparam logic [2:0] CSM_OVERWRITE_IDLE = 3'h1;
    localparam logic [2:0] CSM_OVERWRITE_DETOUR = 3'h2;
    localparam logic [2:0] CSM_OVERWRITE_DESTROY_FIRST = 3'h3;
    localparam logic [2:0] CSM_OVERWRITE_DESTROY_SECOND = 3'h4;

    // Level-2 symmetric cipher standby code
    localparam logic [3:0] CSM_SYM_CIPHER_LEVEL2_IDLE = 4'h1;

    // Accepted-code masks, bit n set means code n is accepted
    localparam logic [15:0] CSM_KA_LEGAL = 16'h000E;
    localparam logic [15:0] CSM_OW_LEGAL = 16'h001E;
    localparam logic [15:0] CSM_L2_LEGAL = 16'hC31E;

endpackage

//--- logic/csm_mode_reg.sv
`timescale 1ns/100ps
module csm_mode_reg
    import csm_pkg::*;
#(
    parameter int unsigned W = 3,
    parameter logic [15:0] LEGAL = 16'h000E,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic core_clk, // Device clock
    input wire logic reset, // Async reset, active high
    input wire logic wr_en, // Host write strobe for this register
    input wire logic [W-1:0] wdata, // Code written by the host
    output logic [W-1:0] mode_q, // Current commanded state
    output logic cmd_q, // One-cycle pulse after an accepted write
    output logic reject // High when the written code is not accepted
);

    logic accept;

    // Unlisted codes never reach the state machine
    assign accept = wr_en && LEGAL[wdata];
    assign reject = wr_en && !LEGAL[wdata];

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mode_q <= RST;
        end else if (accept) begin
            mode_q <= wdata;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cmd_q <= 1'b0;
        end else begin
            cmd_q <= accept;
        end
    end

endmodule

//--- logic/csm_opmode_regs.sv
`timescale 1ns/100ps
module csm_opmode_regs
    import csm_pkg::*;
(
    input wire logic core_clk, // Device clock
    input wire logic reset, // Async reset, active high
    input wire logic reg_wr, // Register write strobe
    input wire logic reg_rd, // Register read strobe
    input wire logic [CSM_ADDR_W-1:0] reg_addr, // Register address
    input wire logic [CSM_DATA_W-1:0] reg_wdata, // Write data
    output logic [CSM_DATA_W-1:0] reg_rdata, // Read data, registered
    output logic reg_rd_valid, // Read data valid pulse
    output logic wr_ignored, // Write dropped: unmapped or bad code
    output logic [CSM_KA_W-1:0] key_agreement_mode_field, // Key-agree state
    output logic key_agreement_cmd, // Pulse on accepted write
    output logic [CSM_OW_W-1:0] overwrite_mode_field, // Overwrite state
    output logic overwrite_cmd, // Pulse on accepted write
    output logic [CSM_L2_W-1:0] sym_cipher_level2_mode_field, // L2 state
    output logic sym_cipher_level2_cmd, // Pulse on accepted write
    output logic id_counter_backup_start, // Sequence running level
    output logic backup_go, // Pulse when a sequence is launched
    input wire logic backup_done_flag // Sequence finished pulse
);

    typedef enum logic {
        BK_IDLE = 1'b0,
        BK_RUN = 1'b1
    } csm_bk_state_t;

    logic sel_ka;
    logic sel_bk;
    logic sel_ow;
    logic sel_l2;
    logic mapped;
    logic rej_ka;
    logic rej_ow;
    logic rej_l2;
    logic bk_start;
    logic bk_running;
    logic wr_refused;
    csm_bk_state_t bk_state_q;
    csm_bk_state_t bk_state_d;
    logic backup_go_q;
    logic [CSM_DATA_W-1:0] rdata_q;
    logic [CSM_DATA_W-1:0] rdata_d;
    logic rd_valid_q;
    logic wr_ignored_q;

    // Full-width compare, so no alias address reaches a mode register
    function automatic logic addr_hit(
        input logic [CSM_ADDR_W-1:0] addr,
        input logic [CSM_ADDR_W-1:0] base
    );
        return addr == base;
    endfunction

    assign sel_ka = addr_hit(reg_addr, CSM_KEY_AGREEMENT_MODE_ADDR);
    assign sel_bk = addr_hit(reg_addr, CSM_ID_COUNTER_BACKUP_CTRL_ADDR);
    assign sel_ow = addr_hit(reg_addr, CSM_MEMORY_OVERWRITE_MODE_ADDR);
    assign sel_l2 = addr_hit(reg_addr, CSM_SYM_CIPHER_LEVEL2_MODE_ADDR);
    assign mapped = sel_ka || sel_bk || sel_ow || sel_l2;
    assign bk_start = reg_wr && sel_bk && reg_wdata[CSM_BACKUP_BIT];
    assign bk_running = (bk_state_q == BK_RUN);

    // Only codes 1..3 reach the key-agreement machine
    csm_mode_reg #(
        .W(CSM_KA_W),
        .LEGAL(CSM_KA_LEGAL),
        .RST(CSM_KA_RST)
    ) u_ka (
        .core_clk(core_clk),
        .reset(reset),
        .wr_en(reg_wr && sel_ka),
        .wdata(reg_wdata[CSM_KA_W-1:0]),
        .mode_q(key_agreement_mode_field),
        .cmd_q(key_agreement_cmd),
        .reject(rej_ka)
    );

    // Codes 0 and 5..7 are dropped instead of trusting the host
    csm_mode_reg #(
        .W(CSM_OW_W),
        .LEGAL(CSM_OW_LEGAL),
        .RST(CSM_OW_RST)
    ) u_ow (
        .core_clk(core_clk),
        .reset(reset),
        .wr_en(reg_wr && sel_ow),
        .wdata(reg_wdata[CSM_OW_W-1:0]),
        .mode_q(overwrite_mode_field),
        .cmd_q(overwrite_cmd),
        .reject(rej_ow)
    );

    // Codes kept for the hardware control part are refused from the host
    csm_mode_reg #(
        .W(CSM_L2_W),
        .LEGAL(CSM_L2_LEGAL),
        .RST(CSM_L2_RST)
    ) u_l2 (
        .core_clk(core_clk),
        .reset(reset),
        .wr_en(reg_wr && sel_l2),
        .wdata(reg_wdata[CSM_L2_W-1:0]),
        .mode_q(sym_cipher_level2_mode_field),
        .cmd_q(sym_cipher_level2_cmd),
        .reject(rej_l2)
    );

    // Host start wins over a finish that lands in the same cycle
    always_comb begin
        bk_state_d = bk_state_q;
        unique case (bk_state_q)
            BK_IDLE: begin
                if (bk_start) begin
                    bk_state_d = BK_RUN;
                end
            end
            BK_RUN: begin
                if (backup_done_flag && !bk_start) begin
                    bk_state_d = BK_IDLE;
                end
            end
        endcase
    end

    // Status bit is the state itself, so a read never lags the launch
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            bk_state_q <= csm_bk_state_t'(CSM_BACKUP_RST);
        end else begin
            bk_state_q <= bk_state_d;
        end
    end

    // A second start while running does not relaunch the sequence
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            backup_go_q <= 1'b0;
        end else begin
            backup_go_q <= (bk_state_q == BK_IDLE)
                && (bk_state_d == BK_RUN);
        end
    end

    // Reserved bits and unmapped addresses read as zero
    always_comb begin
        rdata_d = '0;
        unique case (reg_addr)
            CSM_KEY_AGREEMENT_MODE_ADDR: begin
                rdata_d[CSM_KA_W-1:0] = key_agreement_mode_field;
            end
            CSM_ID_COUNTER_BACKUP_CTRL_ADDR: begin
                rdata_d[CSM_BACKUP_BIT] = bk_running;
            end
            CSM_MEMORY_OVERWRITE_MODE_ADDR: begin
                rdata_d[CSM_OW_W-1:0] = overwrite_mode_field;
            end
            CSM_SYM_CIPHER_LEVEL2_MODE_ADDR: begin
                rdata_d[CSM_L2_W-1:0] = sym_cipher_level2_mode_field;
            end
            default: begin
                rdata_d = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= reg_rd;
        end
    end

    // Refusal reasons kept apart so each one can be traced on its own
    always_comb begin
        wr_refused = 1'b0;
        if (reg_wr && !mapped) begin
            wr_refused = 1'b1;
        end
        if (rej_ka || rej_ow || rej_l2) begin
            wr_refused = 1'b1;
        end
    end

    // Flagged so firmware slips show up instead of silently vanishing
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wr_ignored_q <= 1'b0;
        end else begin
            wr_ignored_q <= wr_refused;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rd_valid = rd_valid_q;
    assign wr_ignored = wr_ignored_q;
    assign id_counter_backup_start = bk_running;
    assign backup_go = backup_go_q;

endmodule

//--- sim/csm_opmode_regs_asserts.sv
`timescale 1ns/100ps
module csm_opmode_regs_chk
    import csm_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic reset, // Reset
    input wire logic reg_wr, // Write
    input wire logic [CSM_ADDR_W-1:0] reg_addr, // Address
    input wire logic [CSM_DATA_W-1:0] reg_wdata, // Data
    input wire logic wr_ignored, // Refused
    input wire logic [CSM_KA_W-1:0] key_agreement_mode_field, // KA
    input wire logic key_agreement_cmd, // KA pulse
    input wire logic [CSM_OW_W-1:0] overwrite_mode_field, // OW
    input wire logic overwrite_cmd, // OW pulse
    input wire logic [CSM_L2_W-1:0] sym_cipher_level2_mode_field, // L2
    input wire logic sym_cipher_level2_cmd, // L2 pulse
    input wire logic id_counter_backup_start, // Running
    input wire logic backup_go, // Launch
    input wire logic backup_done_flag // Done
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    wire logic ka_w = reg_wr && reg_addr == CSM_KEY_AGREEMENT_MODE_ADDR;
    wire logic ow_w = reg_wr && reg_addr == CSM_MEMORY_OVERWRITE_MODE_ADDR;
    wire logic l2_w = reg_wr && reg_addr == CSM_SYM_CIPHER_LEVEL2_MODE_ADDR;
    wire logic bk_w = reg_wr && reg_addr == CSM_ID_COUNTER_BACKUP_CTRL_ADDR;
    AST_KA_SET: assert property (ka_w && CSM_KA_LEGAL[reg_wdata[2:0]] |=>
        key_agreement_cmd && key_agreement_mode_field == $past(reg_wdata[2:0]))
        else $error("key mode not taken");
    AST_KA_KEEP: assert property (
        !ka_w |=> $stable(key_agreement_mode_field))
        else $error("key mode moved without write");
    AST_KA_BAD: assert property (ka_w && !CSM_KA_LEGAL[reg_wdata[2:0]] |=>
        wr_ignored && !key_agreement_cmd) else $error("bad key code taken");
    AST_OW_SET: assert property (
        ow_w && CSM_OW_LEGAL[reg_wdata[2:0]] |=> overwrite_cmd
        && overwrite_mode_field == $past(reg_wdata[2:0]))
        else $error("ow not set");
    AST_OW_BAD: assert property (
        ow_w && !CSM_OW_LEGAL[reg_wdata[2:0]] |=> wr_ignored
        && !overwrite_cmd && $stable(overwrite_mode_field))
        else $error("bad ow taken");
    AST_L2_SET: assert property (l2_w && CSM_L2_LEGAL[reg_wdata[3:0]] |=>
        sym_cipher_level2_cmd ##0
        sym_cipher_level2_mode_field == $past(reg_wdata[3:0]))
        else $error("level2 not set");
    AST_L2_BAD: assert property (
        l2_w && !CSM_L2_LEGAL[reg_wdata[3:0]] |=> wr_ignored
        && !sym_cipher_level2_cmd && $stable(sym_cipher_level2_mode_field))
        else $error("bad level2 code taken");
    AST_BK_GO: assert property (
        bk_w && reg_wdata[0] && !id_counter_backup_start
        |=> backup_go && id_counter_backup_start) else $error("no launch");
    AST_BK_SET: assert property (
        bk_w && reg_wdata[0] |=> id_counter_backup_start && !wr_ignored)
        else $error("start write lost");
    AST_BK_END: assert property (
        backup_done_flag && !(bk_w && reg_wdata[0])
        |=> !id_counter_backup_start) else $error("backup bit stuck");
    cover property (ka_w ##1 key_agreement_cmd);
    cover property (ow_w ##1 wr_ignored);
    cover property (backup_go ##[1:20] !id_counter_backup_start);
endmodule
bind csm_opmode_regs csm_opmode_regs_chk chk_u (.*);

//--- sim/csm_backup_seq.sv
`timescale 1ns/100ps
module csm_backup_seq #(
    parameter int DLY = 6
) (
    input wire logic core_clk, // Clock
    input wire logic reset, // Reset
    input wire logic backup_go, // Launch
    output logic backup_done_flag // Done
);
    int cnt_q;
    // Fixed sequence length keeps the bench's wait bound simple
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 0;
            backup_done_flag <= 1'b0;
        end else begin
            backup_done_flag <= (cnt_q == 1);
            cnt_q <= backup_go ? DLY : (cnt_q > 0 ? cnt_q - 1 : 0);
        end
    end
endmodule

//--- sim/testbench.sv
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module testbench;
    import csm_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [16:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0;
    logic [7:0] reg_rdata;
    logic reg_rd_valid, wr_ignored, bk_go, bk_done;
    logic [2:0] ka_f, ow_f;
    logic [3:0] l2_f;
    logic ka_cmd, ow_cmd, l2_cmd, bk_run;
    logic [3:0] l2_want = 4'h0;
    int n_fail = 0;
    int cmp_count = 0;
    always #5 core_clk = ~core_clk;
    csm_opmode_regs dut_u (.core_clk(core_clk), .reset(reset),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid), .wr_ignored(wr_ignored),
        .key_agreement_mode_field(ka_f), .key_agreement_cmd(ka_cmd),
        .overwrite_mode_field(ow_f), .overwrite_cmd(ow_cmd),
        .sym_cipher_level2_mode_field(l2_f), .sym_cipher_level2_cmd(l2_cmd),
        .id_counter_backup_start(bk_run), .backup_go(bk_go),
        .backup_done_flag(bk_done));
    csm_backup_seq seq_u (.core_clk(core_clk), .reset(reset),
        .backup_go(bk_go), .backup_done_flag(bk_done));
    // An idle edge before each request keeps strobes from toggling twice
    task automatic wr(input logic [16:0] a, input logic [7:0] d,
        input logic i);
        @(negedge core_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
        `CHK(wr_ignored, i)
    endtask
    task automatic rd(input logic [16:0] a, input logic [7:0] e);
        @(negedge core_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge core_clk);
        reg_rd = 1'b0;
        `CHK(reg_rd_valid, 1'b1)
        `CHK(reg_rdata, e)
    endtask
    task automatic close_out;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge core_clk);
        reset = 1'b0;
        for (int r = 10; r < 16; r++) begin
            rd(17'h10600 + 17'(r), 8'h00);
        end
        rd(17'h10619, 8'h00);
        for (int c = 1; c < 4; c++) begin
            wr(17'h1060A, 8'(c), 1'b0);
            `CHK(ka_cmd, 1'b1)
            `CHK(ka_f, 3'(c))
            rd(17'h1060A, 8'(c));
        end
        wr(17'h1060A, 8'h00, 1'b1);
        `CHK(ka_cmd, 1'b0)
        wr(17'h1060A, 8'h07, 1'b1);
        rd(17'h1060A, 8'h03);
        wr(17'h1060A, 8'hFA, 1'b0);
        rd(17'h1060A, 8'h02);
        wr(17'h1060A, 8'h01, 1'b0);
        `CHK(ka_f, 3'h1)
        for (int c = 1; c < 5; c++) begin
            wr(17'h1060F, 8'(c), 1'b0);
            `CHK(ow_cmd, 1'b1)
            rd(17'h1060F, 8'(c));
        end
        for (int c = 5; c < 9; c++) begin
            wr(17'h1060F, 8'(c & 7), 1'b1);
            `CHK(ow_f, 3'h4)
        end
        rd(17'h1060F, 8'h04);
        wr(17'h1060F, 8'h01, 1'b0);
        `CHK(ow_f, 3'h1)
        for (int c = 0; c < 16; c++) begin
            wr(17'h10619, 8'hF0 | 8'(c), !CSM_L2_LEGAL[c]);
            `CHK(l2_cmd, CSM_L2_LEGAL[c])
            if (CSM_L2_LEGAL[c]) begin
                l2_want = 4'(c);
            end
            `CHK(l2_f, l2_want)
            rd(17'h10619, {4'h0, l2_want});
        end
        wr(17'h10619, 8'h01, 1'b0);
        wr(17'h1060C, 8'h01, 1'b1);
        wr(17'h1060B, 8'h01, 1'b0);
        `CHK(bk_go, 1'b1)
        `CHK(bk_run, 1'b1)
        rd(17'h1060B, 8'h01);
        wr(17'h1060B, 8'h01, 1'b0);
        `CHK(bk_go, 1'b0)
        wr(17'h1060B, 8'h00, 1'b0);
        `CHK(bk_run, 1'b1)
        for (int i = 0; i < 20 && bk_done !== 1'b1; i++) @(negedge core_clk);
        `CHK(bk_done, 1'b1)
        if (n_fail > 0) close_out();
        @(negedge core_clk);
        `CHK(bk_run, 1'b0)
        rd(17'h1060B, 8'h00);
        close_out();
    end
endmodule
